// ---- src/setpoint_ctrl.sv ----
// Purpose: Mode contacts, setpoint group select, ramp and input conditioning
// Assumes: Contacts and keys are pins; samples and computed output on core clock
// Notes:   APB slave with zero wait states
//
// The APB interface to the registers and the placing of the registers were left to the implementer.
`include "sp_defs.svh"
`default_nettype none
module setpoint_ctrl #(
	parameter int unsigned DEBOUNCE_CYC = `DEBOUNCE_MS * (`CLK_HZ / 1000) / 3,
	parameter int unsigned TICK_CYC     = `RAMP_TICK_MS * (`CLK_HZ / 1000),
	parameter int unsigned NPTS         = 11
) (
	// Clock and reset
	input  wire logic              core_clk_i,
	input  wire logic              nrst_i,
	// APB
	input  wire logic [11:0]       paddr_i,
	input  wire logic              psel_i,
	input  wire logic              penable_i,
	input  wire logic              pwrite_i,
	input  wire logic [31:0]       pwdata_i,
	output logic      [31:0]       prdata_o,
	output logic                   pready_o,
	output logic                   pslverr_o,
	// Contact inputs and keys
	input  wire logic              contact_auto_manual_i,
	input  wire logic              contact_run_stop_i,
	input  wire logic              contact_sp_sel_bit0_i,
	input  wire logic              contact_sp_sel_bit1_i,
	input  wire logic              contact_sp_sel_bit2_i,
	input  wire logic              contact_sp_sel_eighth_i,
	input  wire logic              contact_unused_i,
	input  wire logic              contact_remote_local_i,
	input  wire logic              key_up_i,
	input  wire logic              key_down_i,
	// Samples
	input  wire logic [15:0]       process_value_input_i,
	input  wire logic              pv_valid_i,
	input  wire logic [15:0]       remote_setpoint_input_i,
	input  wire logic              remote_valid_i,
	input  wire logic [15:0]       computed_out_i,
	// Results
	output logic      [15:0]       control_out_o,
	output sp_pkg::modes_t         modes_o,
	output logic      [2:0]        setpoint_group_index_o,
	output sp_pkg::group_t         group_o,
	output logic      [15:0]       process_value_o,
	output logic      [15:0]       target_sp_o
);
	localparam int DBW = $clog2(DEBOUNCE_CYC + 1);
	localparam int TKW = $clog2(TICK_CYC + 1);

	// ------------------------------------------------------------
	// Functions
	// ------------------------------------------------------------
	// Returns {hit, index}; no hit keeps the group
	function automatic logic [3:0] decode_sel(input logic [3:0] s);
		decode_sel = 4'h0;
		if (s == 4'h8) begin
			decode_sel = 4'hF;
		end else if (!s[3] && s[2:0] != 3'h0) begin
			decode_sel = {1'b1, s[2:0] - 3'h1};
		end
	endfunction

	function automatic logic [15:0] lag(input logic [15:0] y, input logic [15:0] x, input logic [3:0] sh);
		logic signed [16:0] d;
		d = $signed({x[15], x}) - $signed({y[15], y});
		d = d >>> sh;
		lag = (sh == 4'h0) ? x : y + d[15:0];
	endfunction

	// Full scale in gives full scale out; negative gives zero
	function automatic logic [15:0] root(input logic [15:0] x);
		logic [29:0] v;
		logic [14:0] q;
		logic [14:0] t;
		v = {x[14:0], 15'h0000};
		q = 15'h0000;
		for (int i = 14; i >= 0; i--) begin
			t = q | (15'h0001 << i);
			if ({15'h0000, t} * {15'h0000, t} <= v) begin
				q = t;
			end
		end
		root = x[15] ? 16'h0000 : {1'b0, q};
	endfunction

	// ------------------------------------------------------------
	// Contact synchroniser and debounce
	// ------------------------------------------------------------
	logic [9:0]     raw;
	logic [9:0]     sync1_ff;
	logic [9:0]     sync2_ff;
	logic [9:0]     hist1_ff;
	logic [9:0]     hist2_ff;
	logic [9:0]     stable_ff;
	logic [DBW-1:0] db_cnt_ff;
	logic           db_tick;

	assign raw = {key_down_i, key_up_i, contact_remote_local_i, contact_unused_i,
		contact_sp_sel_eighth_i, contact_sp_sel_bit2_i, contact_sp_sel_bit1_i,
		contact_sp_sel_bit0_i, contact_run_stop_i, contact_auto_manual_i};
	assign db_tick = (db_cnt_ff == DBW'(DEBOUNCE_CYC - 1));

	always_ff @(posedge core_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			sync1_ff <= '0;
			sync2_ff <= '0;
		end else begin
			sync1_ff <= raw; // [RULE19]
			sync2_ff <= sync1_ff;
		end
	end

	always_ff @(posedge core_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			db_cnt_ff <= '0;
		end else begin
			db_cnt_ff <= db_tick ? '0 : db_cnt_ff + DBW'(1);
		end
	end

	// A bit flips after three equal samples one period apart
	always_ff @(posedge core_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			hist1_ff  <= '0;
			hist2_ff  <= '0;
			stable_ff <= '0;
		end else if (db_tick) begin
			hist1_ff  <= sync2_ff;
			hist2_ff  <= hist1_ff;
			stable_ff <= (sync2_ff & hist1_ff & hist2_ff) | (stable_ff & (sync2_ff | hist1_ff | hist2_ff)); // [RULE19]
		end
	end

	// ------------------------------------------------------------
	// Modes and group selection
	// ------------------------------------------------------------
	logic [3:0] sel;
	logic [3:0] sel_prev_ff;
	logic [3:0] dec;
	logic [2:0] idx_ff;
	logic       key_wr;
	logic       apb_wr;

	assign modes_o.auto_mode = stable_ff[0]; // [RULE1]
	assign modes_o.stopped   = stable_ff[1]; // [RULE3]
	assign modes_o.remote    = stable_ff[7]; // [RULE9]
	assign sel    = stable_ff[5:2];
	assign dec    = decode_sel(sel); // [RULE6]
	assign apb_wr = psel_i && penable_i && pwrite_i && paddr_i[1:0] == 2'b00;
	assign key_wr = apb_wr && (paddr_i == `OFS_CTRL);
	assign setpoint_group_index_o = idx_ff;

	// Only a pattern change acts, so a held pattern cannot undo a key write
	always_ff @(posedge core_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			sel_prev_ff <= '0;
			idx_ff      <= '0;
		end else begin
			sel_prev_ff <= sel;
			if (sel != sel_prev_ff && dec[3]) begin
				idx_ff <= dec[2:0]; // [RULE11]
			end else if (key_wr) begin
				idx_ff <= pwdata_i[2:0]; // [RULE11]
			end
			// All-off and undefined patterns hold [RULE7] [RULE18]
		end
	end

	// ------------------------------------------------------------
	// Configuration registers
	// ------------------------------------------------------------
	logic [15:0] preset_ff;
	logic [15:0] mstep_ff;
	logic [15:0] rate_up_ff;
	logic [15:0] rate_dn_ff;
	logic [5:0]  cfg_ff;
	logic [15:0] filt_ff;
	logic [15:0] pv_bias_op_ff;
	logic [15:0] pv_bias_su_ff;
	logic [15:0] rmt_bias_ff;
	logic [15:0] ratio_ff;
	logic [15:0] ratio_bias_ff;
	logic [15:0] comm_sp_ff;
	logic [15:0] lin_a_ff [NPTS];
	logic [15:0] lin_b_ff [NPTS];

	always_ff @(posedge core_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			preset_ff     <= '0;
			mstep_ff      <= `RST_MSTEP;
			rate_up_ff    <= '0;
			rate_dn_ff    <= '0;
			cfg_ff        <= '0;
			filt_ff       <= '0;
			pv_bias_op_ff <= '0;
			pv_bias_su_ff <= '0;
			rmt_bias_ff   <= '0;
			ratio_ff      <= `RST_RATIO;
			ratio_bias_ff <= '0;
			comm_sp_ff    <= '0;
		end else if (apb_wr) begin
			unique case (paddr_i)
				`OFS_PRESET:     preset_ff     <= pwdata_i[15:0];
				`OFS_MSTEP:      mstep_ff      <= pwdata_i[15:0];
				`OFS_RATE_UP:    rate_up_ff    <= pwdata_i[15:0];
				`OFS_RATE_DN:    rate_dn_ff    <= pwdata_i[15:0];
				`OFS_CFG:        cfg_ff        <= pwdata_i[5:0];
				`OFS_FILT:       filt_ff       <= pwdata_i[15:0];
				`OFS_PV_BIAS_OP: pv_bias_op_ff <= pwdata_i[15:0];
				`OFS_PV_BIAS_SU: pv_bias_su_ff <= pwdata_i[15:0];
				`OFS_RMT_BIAS:   rmt_bias_ff   <= pwdata_i[15:0];
				`OFS_RATIO:      ratio_ff      <= pwdata_i[15:0];
				`OFS_RATIO_BIAS: ratio_bias_ff <= pwdata_i[15:0];
				`OFS_COMM_SP:    comm_sp_ff    <= pwdata_i[15:0]; // [RULE17]
				default:         ;
			endcase
		end
	end

	always_ff @(posedge core_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			for (int i = 0; i < NPTS; i++) begin
				lin_a_ff[i] <= '0;
				lin_b_ff[i] <= '0;
			end
		end else if (apb_wr) begin
			for (int i = 0; i < NPTS; i++) begin
				if (paddr_i[5:2] == 4'(i) && paddr_i[11:6] == `LIN_A_PAGE) begin
					lin_a_ff[i] <= pwdata_i[15:0];
				end
				if (paddr_i[5:2] == 4'(i) && paddr_i[11:6] == `LIN_B_PAGE) begin
					lin_b_ff[i] <= pwdata_i[15:0];
				end
			end
		end
	end

	// ------------------------------------------------------------
	// Group storage and scan of the active group
	// ------------------------------------------------------------
	logic [2:0]  fld_ff;
	logic [2:0]  fld_d_ff;
	logic [15:0] mem_a_data;
	logic [15:0] mem_b_data;
	logic [15:0] grp_ff [7];
	logic        mem_wr;

	assign mem_wr = apb_wr && (paddr_i[11:8] == `GROUP_PAGE);

	group_mem #(
		.DW (16),
		.AW (6)
	) u_mem (
		.core_clk_i  (core_clk_i),
		.nrst_i      (nrst_i),
		.wr_en_i     (mem_wr),
		.wr_addr_i   (paddr_i[7:2]),
		.wr_data_i   (pwdata_i[15:0]),
		.rd_a_addr_i (paddr_i[7:2]),
		.rd_a_data_o (mem_a_data),
		.rd_b_addr_i ({idx_ff, fld_ff}),
		.rd_b_data_o (mem_b_data)
	);

	// Fields refresh in turn; a group switch settles in eight cycles
	always_ff @(posedge core_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			fld_ff   <= '0;
			fld_d_ff <= '0;
			for (int i = 0; i < 7; i++) begin
				grp_ff[i] <= '0;
			end
		end else begin
			fld_ff   <= (fld_ff == 3'h6) ? 3'h0 : fld_ff + 3'h1;
			fld_d_ff <= fld_ff;
			grp_ff[fld_d_ff] <= mem_b_data; // [RULE10]
		end
	end

	assign group_o = {grp_ff[6], grp_ff[5], grp_ff[4], grp_ff[3], grp_ff[2], grp_ff[1], grp_ff[0]};

	// ------------------------------------------------------------
	// Process value and remote input conditioning
	// ------------------------------------------------------------
	logic [15:0] pv_in;
	logic [15:0] pv_a_ff;
	logic [15:0] pv_b_ff;
	logic [15:0] pv_ff;
	logic [15:0] lin_out;
	logic [15:0] rm_in;
	logic [15:0] rm_a_ff;
	logic [15:0] rm_b_ff;
	logic [31:0] rm_prod;
	logic [15:0] rm_ratio;
	logic [15:0] remote_sp;
	logic [3:0]  seg;

	always_comb begin
		pv_in = process_value_input_i + pv_bias_su_ff;
		pv_in = cfg_ff[`CFG_PV_SQRT] ? root(pv_in) : pv_in;
		seg = 4'h0;
		for (int i = 1; i < NPTS; i++) begin
			if ($signed(pv_a_ff) >= $signed(lin_a_ff[i])) begin
				seg = 4'(i);
			end
		end
		unique case (sp_pkg::lin_mode_t'(cfg_ff[`CFG_LIN_LO +: 2]))
			sp_pkg::LIN_APPROX: lin_out = lin_b_ff[seg];
			sp_pkg::LIN_BIAS:   lin_out = pv_a_ff + lin_b_ff[seg];
			default:            lin_out = pv_a_ff;
		endcase
		rm_in = remote_setpoint_input_i + rmt_bias_ff;
		rm_in = cfg_ff[`CFG_RMT_SQRT] ? root(rm_in) : rm_in;
		rm_prod  = 32'($signed(rm_a_ff) * $signed(ratio_ff));
		rm_ratio = rm_prod[23:8] + ratio_bias_ff;
	end

	// Not gated by stop: measurement never pauses [RULE5]
	always_ff @(posedge core_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			pv_a_ff <= '0;
			pv_b_ff <= '0;
			pv_ff   <= '0;
		end else if (pv_valid_i) begin
			pv_a_ff <= lag(pv_a_ff, pv_in, filt_ff[7:4]); // [RULE14] [RULE16]
			pv_b_ff <= lin_out; // [RULE14]
			pv_ff   <= lag(pv_ff, pv_b_ff + pv_bias_op_ff, filt_ff[3:0]); // [RULE16]
		end
	end

	always_ff @(posedge core_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			rm_a_ff <= '0;
			rm_b_ff <= '0;
		end else if (remote_valid_i) begin
			rm_a_ff <= lag(rm_a_ff, rm_in, filt_ff[15:12]); // [RULE15]
			rm_b_ff <= lag(rm_b_ff, rm_ratio, filt_ff[11:8]); // [RULE15]
		end
	end

	assign remote_sp = cfg_ff[`CFG_COMM_RMT] ? comm_sp_ff : rm_b_ff; // [RULE17]
	assign process_value_o = pv_ff;

	// ------------------------------------------------------------
	// Setpoint ramp
	// ------------------------------------------------------------
	logic [TKW-1:0] tick_cnt_ff;
	logic           tick;
	logic [15:0]    tgt;
	logic [15:0]    rate;
	logic [15:0]    unit_s;
	logic [16:0]    acc_ff;
	logic [15:0]    eff_ff;
	logic           rising;

	assign tick   = (tick_cnt_ff == TKW'(TICK_CYC - 1));
	assign tgt    = modes_o.remote ? remote_sp : group_o.sp; // [RULE9]
	assign rising = $signed(tgt) > $signed(eff_ff);
	assign rate   = rising ? rate_up_ff : rate_dn_ff; // [RULE12]
	assign unit_s = cfg_ff[`CFG_UNIT_HOUR] ? `UNIT_HOUR_S : `UNIT_MIN_S; // [RULE13]
	assign target_sp_o = eff_ff;

	always_ff @(posedge core_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			tick_cnt_ff <= '0;
		end else begin
			tick_cnt_ff <= tick ? '0 : tick_cnt_ff + TKW'(1);
		end
	end

	// Rate added each second; each whole unit moves one count
	always_ff @(posedge core_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			acc_ff <= '0;
			eff_ff <= '0;
		end else if (rate == 16'h0000 || eff_ff == tgt) begin
			acc_ff <= '0;
			eff_ff <= tgt;
		end else if (tick) begin
			acc_ff <= acc_ff + {1'b0, rate}; // [RULE13]
		end else if (acc_ff >= {1'b0, unit_s}) begin
			acc_ff <= acc_ff - {1'b0, unit_s};
			eff_ff <= rising ? eff_ff + 16'h0001 : eff_ff - 16'h0001; // [RULE12]
		end
	end

	// ------------------------------------------------------------
	// Manual output and control output
	// ------------------------------------------------------------
	logic        up_prev_ff;
	logic        dn_prev_ff;
	logic [15:0] manual_ff;
	logic [15:0] ctl_ff;
	logic [16:0] up_sum;
	logic [16:0] dn_dif;

	assign up_sum = {1'b0, manual_ff} + {1'b0, mstep_ff};
	assign dn_dif = {1'b0, manual_ff} - {1'b0, mstep_ff};

	always_ff @(posedge core_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			up_prev_ff <= 1'b0;
			dn_prev_ff <= 1'b0;
			manual_ff  <= '0;
		end else begin
			up_prev_ff <= stable_ff[8];
			dn_prev_ff <= stable_ff[9];
			if (modes_o.auto_mode) begin
				manual_ff <= computed_out_i;
			end else if (stable_ff[8] && !up_prev_ff) begin
				manual_ff <= up_sum[16] ? 16'hFFFF : up_sum[15:0]; // [RULE2]
			end else if (stable_ff[9] && !dn_prev_ff) begin
				manual_ff <= dn_dif[16] ? 16'h0000 : dn_dif[15:0]; // [RULE2]
			end
		end
	end

	// Stop outranks manual
	always_ff @(posedge core_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			ctl_ff <= '0;
		end else if (modes_o.stopped) begin
			ctl_ff <= preset_ff; // [RULE4]
		end else begin
			ctl_ff <= modes_o.auto_mode ? computed_out_i : manual_ff; // [RULE1]
		end
	end

	assign control_out_o = ctl_ff;

	// ------------------------------------------------------------
	// APB read path
	// ------------------------------------------------------------
	logic [31:0] rd_val;
	logic        rd_err;
	logic [31:0] prdata_ff;
	logic        err_ff;
	logic        mem_rd_ff;

	// The unused contact appears in status only [RULE8]
	always_comb begin
		rd_val = 32'h0000_0000;
		rd_err = 1'b0;
		for (int i = 0; i < NPTS; i++) begin
			if (paddr_i[5:2] == 4'(i) && paddr_i[11:6] == `LIN_A_PAGE) rd_val = {16'h0000, lin_a_ff[i]};
			if (paddr_i[5:2] == 4'(i) && paddr_i[11:6] == `LIN_B_PAGE) rd_val = {16'h0000, lin_b_ff[i]};
		end
		unique case (paddr_i)
			`OFS_CTRL:       rd_val = {29'h0000_0000, idx_ff};
			`OFS_STATUS:     rd_val = {6'h00, stable_ff, 9'h000, modes_o, 1'b0, idx_ff};
			`OFS_PRESET:     rd_val = {16'h0000, preset_ff};
			`OFS_MSTEP:      rd_val = {16'h0000, mstep_ff};
			`OFS_RATE_UP:    rd_val = {16'h0000, rate_up_ff};
			`OFS_RATE_DN:    rd_val = {16'h0000, rate_dn_ff};
			`OFS_CFG:        rd_val = {26'h000_0000, cfg_ff};
			`OFS_FILT:       rd_val = {16'h0000, filt_ff};
			`OFS_PV_BIAS_OP: rd_val = {16'h0000, pv_bias_op_ff};
			`OFS_PV_BIAS_SU: rd_val = {16'h0000, pv_bias_su_ff};
			`OFS_RMT_BIAS:   rd_val = {16'h0000, rmt_bias_ff};
			`OFS_RATIO:      rd_val = {16'h0000, ratio_ff};
			`OFS_RATIO_BIAS: rd_val = {16'h0000, ratio_bias_ff};
			`OFS_COMM_SP:    rd_val = {16'h0000, comm_sp_ff};
			`OFS_PV:         rd_val = {16'h0000, pv_ff};
			`OFS_SP:         rd_val = {16'h0000, eff_ff};
			default: begin
				if (paddr_i[11:8] != `GROUP_PAGE && !(paddr_i[11:6] == `LIN_A_PAGE && paddr_i[5:2] < 4'(NPTS))
					&& !(paddr_i[11:6] == `LIN_B_PAGE && paddr_i[5:2] < 4'(NPTS))) begin
					rd_err = 1'b1;
				end
			end
		endcase
		if (paddr_i[1:0] != 2'b00) begin
			rd_err = 1'b1;
		end
	end

	// Taken at setup, shown in access
	always_ff @(posedge core_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			prdata_ff <= '0;
			err_ff    <= 1'b0;
			mem_rd_ff <= 1'b0;
		end else if (psel_i && !penable_i) begin
			prdata_ff <= rd_err ? 32'h0000_0000 : rd_val;
			err_ff    <= rd_err;
			mem_rd_ff <= (paddr_i[11:8] == `GROUP_PAGE) && !pwrite_i && !rd_err;
		end
	end

	assign prdata_o  = mem_rd_ff ? {16'h0000, mem_a_data} : prdata_ff;
	assign pready_o  = 1'b1;
	assign pslverr_o = psel_i && penable_i && err_ff;
endmodule
`default_nettype wire

// ---- src/sp_defs.svh ----
// Purpose: Constants for the setpoint block
// Assumes: APB registers, one 40 MHz clock
// Notes:   Offsets are byte addresses, every register one 32-bit word
//
// How it works
// RULE1 - Auto contact ON: automatic; OFF: manual.
// RULE2 - Manual: up/down keys step the output.
// RULE3 - Stop contact ON stops control.
// RULE4 - Stopped: output shows the preset.
// RULE5 - Measurement runs on while stopped.
// RULE6 - Bits 0-2 pick groups 1-7; eighth alone group 8.
// RULE7 - All select contacts OFF: keep group.
// RULE8 - Unused contact affects nothing.
// RULE9 - Remote contact: setpoint from remote path.
// RULE10 - Eight setpoint/PID groups; index picks one.
// RULE11 - Index set by key write or contacts.
// RULE12 - Ramp limit with own rise and fall rates.
// RULE13 - Rates per minute or per hour.
// RULE14 - PV: bias, root, lag, ten-segment linearizer.
// RULE15 - Remote: bias, root, lag, ratio and bias.
// RULE16 - Operating bias/filter normal; setup ones fixed.
// RULE17 - Remote setpoint may come over communication.
// RULE18 - Undefined select patterns keep the group.
// RULE19 - Contacts synchronised and debounced first.
`ifndef SP_DEFS_SVH
`define SP_DEFS_SVH

// ------------------------------------------------------------
// Timing
// ------------------------------------------------------------
`define CLK_HZ        40000000
`define DEBOUNCE_MS   12
`define RAMP_TICK_MS  1000
`define UNIT_MIN_S    16'h003C
`define UNIT_HOUR_S   16'h0E10

// ------------------------------------------------------------
// Register offsets
// ------------------------------------------------------------
`define OFS_CTRL       12'h000
`define OFS_STATUS     12'h004
`define OFS_PRESET     12'h008
`define OFS_MSTEP      12'h00C
`define OFS_RATE_UP    12'h010
`define OFS_RATE_DN    12'h014
`define OFS_CFG        12'h018
`define OFS_FILT       12'h01C
`define OFS_PV_BIAS_OP 12'h020
`define OFS_PV_BIAS_SU 12'h024
`define OFS_RMT_BIAS   12'h028
`define OFS_RATIO      12'h02C
`define OFS_RATIO_BIAS 12'h030
`define OFS_COMM_SP    12'h034
`define OFS_PV         12'h038
`define OFS_SP         12'h03C
`define LIN_A_PAGE     6'h02
`define LIN_B_PAGE     6'h03
`define GROUP_PAGE     4'h1

// ------------------------------------------------------------
// Field positions and reset values
// ------------------------------------------------------------
`define CFG_UNIT_HOUR  0
`define CFG_COMM_RMT   1
`define CFG_LIN_LO     2
`define CFG_PV_SQRT    4
`define CFG_RMT_SQRT   5
`define RST_MSTEP      16'h0001
`define RST_RATIO      16'h0100

`endif

// ---- src/sp_pkg.sv ----
// Purpose: Types for the setpoint selection block
// Assumes: 16-bit engineering values
// Notes:   Group words are stored in field order
`default_nettype none
package sp_pkg;
	typedef struct packed {
		logic [15:0] dc;
		logic [15:0] ic;
		logic [15:0] pc;
		logic [15:0] d;
		logic [15:0] i;
		logic [15:0] p;
		logic [15:0] sp;
	} group_t;

	typedef struct packed {
		logic auto_mode;
		logic stopped;
		logic remote;
	} modes_t;

	typedef enum logic [1:0] {
		LIN_OFF    = 2'b00,
		LIN_APPROX = 2'b01,
		LIN_BIAS   = 2'b10
	} lin_mode_t;
endpackage
`default_nettype wire

// ---- src/group_mem.sv ----
// Purpose: Storage of the setpoint/PID groups, two registered read ports
// Assumes: One write port
// Notes:   Contents are not reset
`default_nettype none
module group_mem #(
	parameter int unsigned DW = 16,
	parameter int unsigned AW = 6
) (
	// Clock and reset
	input  wire logic          core_clk_i,
	input  wire logic          nrst_i,
	// Write port
	input  wire logic          wr_en_i,
	input  wire logic [AW-1:0] wr_addr_i,
	input  wire logic [DW-1:0] wr_data_i,
	// Read ports
	input  wire logic [AW-1:0] rd_a_addr_i,
	output logic      [DW-1:0] rd_a_data_o,
	input  wire logic [AW-1:0] rd_b_addr_i,
	output logic      [DW-1:0] rd_b_data_o
);
	logic [DW-1:0] mem [0:(1<<AW)-1];

	always_ff @(posedge core_clk_i) begin
		if (wr_en_i) begin
			mem[wr_addr_i] <= wr_data_i;
		end
	end

	always_ff @(posedge core_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			rd_a_data_o <= '0;
			rd_b_data_o <= '0;
		end else begin
			rd_a_data_o <= mem[rd_a_addr_i];
			rd_b_data_o <= mem[rd_b_addr_i];
		end
	end
endmodule
`default_nettype wire

// ---- tb/setpoint_ctrl_checker.sv ----
// Purpose: Port assertions for setpoint_ctrl
// Assumes: One clock, asynchronous active-low reset
// Notes:   Contact causes are looked for three cycles back
`default_nettype none
module setpoint_ctrl_checker (
	// Clock, reset and bus
	input wire logic           core_clk_i,
	input wire logic           nrst_i,
	input wire logic [11:0]    paddr_i,
	input wire logic           psel_i,
	input wire logic           penable_i,
	input wire logic           pwrite_i,
	input wire logic           pready_o,
	input wire logic           pslverr_o,
	// Contacts and results
	input wire logic           contact_auto_manual_i,
	input wire logic           contact_run_stop_i,
	input wire logic           contact_remote_local_i,
	input wire logic [15:0]    computed_out_i,
	input wire logic [15:0]    control_out_o,
	input wire sp_pkg::modes_t modes_o
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (!nrst_i);
	logic wr;
	assign wr = psel_i && penable_i && pwrite_i;
	sequence s_stop2;
		modes_o.stopped [*2];
	endsequence
	sequence s_run_auto;
		modes_o.auto_mode && !modes_o.stopped;
	endsequence
	AST_AUTO_OUT: assert property (s_run_auto |=> control_out_o == $past(computed_out_i))
		else $error("output not the computed value");
	// Only a write two cycles back, to any register, may move a stopped output
	AST_STOP_HOLD: assert property (s_stop2 ##1 !$past(wr, 2) |-> $stable(control_out_o))
		else $error("output moved while stopped");
	AST_AUTO_CAUSE: assert property ($changed(modes_o.auto_mode) |-> modes_o.auto_mode == $past(contact_auto_manual_i, 3))
		else $error("auto mode without contact");
	AST_STOP_CAUSE: assert property ($changed(modes_o.stopped) |-> modes_o.stopped == $past(contact_run_stop_i, 3))
		else $error("stop mode without contact");
	AST_RMT_CAUSE: assert property ($changed(modes_o.remote) |-> modes_o.remote == $past(contact_remote_local_i, 3))
		else $error("remote mode without contact");
	AST_PREADY: assert property (pready_o)
		else $error("ready low");
	AST_MISALIGN: assert property (psel_i && penable_i && paddr_i[1:0] != 2'h0 |-> pslverr_o)
		else $error("misalignment not refused");
	AST_ERR_SCOPE: assert property (pslverr_o |-> psel_i && penable_i)
		else $error("error outside access");
endmodule
bind setpoint_ctrl setpoint_ctrl_checker u_setpoint_ctrl_checker (.core_clk_i, .nrst_i, .paddr_i, .psel_i, .penable_i,
	.pwrite_i, .pready_o, .pslverr_o, .contact_auto_manual_i, .contact_run_stop_i, .contact_remote_local_i,
	.computed_out_i, .control_out_o, .modes_o);
`default_nettype wire

// ---- tb/plant_model.sv ----
// Purpose: Plant contacts and analog samples for the setpoint block
// Assumes: Contacts are clean levels; a sample every fourth cycle
// Notes:   Bits 0 auto, 1 stop, 2-4 select, 5 eighth, 6 unused, 7 remote
`default_nettype none
module plant_model (
	// Clock and commands
	input  wire logic        clk_i,
	input  wire logic [7:0]  contacts_i,
	input  wire logic [15:0] level_i,
	// Toward the block
	output logic      [7:0]  pins_o,
	output logic      [15:0] sample_o,
	output logic             sample_valid_o
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [1:0] phase_ff;
	initial {pins_o, sample_o, sample_valid_o, phase_ff} = '0;
	always @(posedge clk_i) begin
		pins_o <= contacts_i;
		phase_ff <= phase_ff + 2'h1;
		sample_valid_o <= (phase_ff == 2'h0);
		sample_o <= level_i;
	end
endmodule
`default_nettype wire

// ---- tb/tb_top.sv ----
// Purpose: Self-checking bench for setpoint_ctrl
// Assumes: Short debounce and tick parameters
// Notes:   Expected results queue up; a monitor compares them
`default_nettype none
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic           core_clk_i, nrst_i, psel_i, penable_i, pwrite_i, pready_o, pslverr_o, smp_v, er;
	logic [11:0]    paddr_i;
	logic [31:0]    pwdata_i, prdata_o, rd;
	logic [15:0]    computed_out_i, control_out_o, process_value_o, target_sp_o, lvl, smp, old;
	logic [7:0]     ct, pins, rnd;
	logic [1:0]     ky;
	logic [2:0]     setpoint_group_index_o;
	sp_pkg::modes_t modes_o;
	sp_pkg::group_t group_o;
	typedef struct {int k; logic [31:0] v;} note_t;
	note_t q[$];
	int err_count, checked, cyc;
	event got;
	string nm[8] = '{"ctl", "idx", "sp", "pv", "rdata", "err", "modes", "tsp"};
	plant_model u_plant_model (.clk_i(core_clk_i), .contacts_i(ct), .level_i(lvl), .pins_o(pins), .sample_o(smp),
		.sample_valid_o(smp_v));
	setpoint_ctrl #(.DEBOUNCE_CYC(4), .TICK_CYC(50)) u_setpoint_ctrl (.core_clk_i, .nrst_i, .paddr_i, .psel_i,
		.penable_i, .pwrite_i, .pwdata_i, .prdata_o, .pready_o, .pslverr_o, .contact_auto_manual_i(pins[0]),
		.contact_run_stop_i(pins[1]), .contact_sp_sel_bit0_i(pins[2]), .contact_sp_sel_bit1_i(pins[3]),
		.contact_sp_sel_bit2_i(pins[4]), .contact_sp_sel_eighth_i(pins[5]), .contact_unused_i(pins[6]),
		.contact_remote_local_i(pins[7]), .key_up_i(ky[0]), .key_down_i(ky[1]), .process_value_input_i(smp),
		.pv_valid_i(smp_v), .remote_setpoint_input_i(smp), .remote_valid_i(smp_v), .computed_out_i,
		.control_out_o, .modes_o, .setpoint_group_index_o, .group_o, .process_value_o, .target_sp_o);
	function automatic logic [7:0] lfsr(input logic [7:0] s);
		return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
	endfunction
	function automatic logic [31:0] seen(input int k);
		case (k)
			0: return {16'h0, control_out_o};
			1: return {29'h0, setpoint_group_index_o};
			2: return {16'h0, group_o.sp};
			3: return {16'h0, process_value_o};
			4: return rd;
			5: return {31'h0, er};
			7: return {16'h0, target_sp_o};
			default: return {29'h0, modes_o};
		endcase
	endfunction
	task automatic cmp(input note_t n);
		checked++;
		if (seen(n.k) !== n.v) begin
			err_count++;
			$display("[ERR] %s expected %h seen %h", nm[n.k], n.v, seen(n.k));
		end
	endtask
	always @(got) cmp(q.pop_front());
	task automatic note(input int k, input logic [31:0] v);
		@(negedge core_clk_i);
		q.push_back('{k, v});
		-> got;
	endtask
	task automatic summarize;
		$display("checked %0d err_count %0d", checked, err_count);
		if (err_count == 0 && checked > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge core_clk_i);
		psel_i <= 1'h1;
		penable_i <= 1'h0;
		pwrite_i <= w;
		paddr_i <= a;
		pwdata_i <= d;
		@(posedge core_clk_i);
		penable_i <= 1'h1;
		do @(posedge core_clk_i); while (pready_o !== 1'h1);
		rd = prdata_o;
		er = pslverr_o;
		psel_i <= 1'h0;
		penable_i <= 1'h0;
	endtask
	// Sync, debounce and group refresh
	task automatic settle;
		repeat (40) @(posedge core_clk_i);
	endtask
	task automatic set_ct(input logic [9:0] v);
		@(posedge core_clk_i);
		{ky, ct} <= v;
		settle;
	endtask
	initial begin
		core_clk_i = 1'h0;
		forever #12.5 core_clk_i = ~core_clk_i;
	end
	always @(posedge core_clk_i) begin
		cyc++;
		if (cyc == 5000) begin
			err_count++;
			summarize;
		end
	end
	initial begin
		{nrst_i, psel_i, penable_i, pwrite_i, paddr_i, pwdata_i, ky, ct, lvl, computed_out_i} = '0;
		rnd = 8'h54;
		repeat (2) @(posedge core_clk_i);
		nrst_i <= 1'h1;
		apb(1'h0, 12'h00C, 32'h0);
		note(4, 32'h1);
		apb(1'h0, 12'h02C, 32'h0);
		note(4, 32'h100);
		apb(1'h1, 12'h002, 32'h0);
		note(5, 32'h1);
		apb(1'h0, 12'h040, 32'h0);
		note(5, 32'h1);
		note(4, 32'h0);
		apb(1'h1, 12'h008, 32'h1234);
		for (int g = 0; g < 8; g++) begin
			rnd = lfsr(rnd);
			apb(1'h1, 12'h100 + 12'(g * 32), {16'h0, rnd, ~rnd});
			set_ct(g == 7 ? 10'h020 : 10'((g + 1) << 2));
			note(1, g);
			note(2, {16'h0, rnd, ~rnd});
		end
		set_ct(10'h000);
		note(1, 7);
		set_ct(10'h024);
		note(1, 7);
		apb(1'h1, 12'h000, 32'h3);
		apb(1'h0, 12'h000, 32'h0);
		note(4, 32'h3);
		set_ct(10'h064);
		note(1, 3);
		note(6, 0);
		set_ct(10'h066);
		note(0, 32'h1234);
		note(6, 3'b010);
		rnd = lfsr(rnd);
		lvl <= {rnd, ~rnd};
		settle;
		note(3, {16'h0, rnd, ~rnd});
		rnd = lfsr(rnd);
		old = {rnd, 8'h5A};
		computed_out_i <= old;
		set_ct(10'h065);
		note(0, {16'h0, old});
		set_ct(10'h064);
		computed_out_i <= 16'h0F0F;
		settle;
		note(0, {16'h0, old});
		set_ct(10'h164);
		note(0, {16'h0, old + 16'h1});
		set_ct(10'h264);
		note(0, {16'h0, old});
		set_ct(10'h0E4);
		note(6, 3'b001);
		note(7, {16'h0, lvl});
		repeat (2) @(posedge core_clk_i);
		summarize;
	end
endmodule
`default_nettype wire
